// *** adcra_defs.svh ***
/*
   constants for the converter register access port: widths, field positions,
   address bit positions, reset values and calibration group bounds.
   assumes it is included by its bare name from design files.
*/
`ifndef ADCRA_DEFS_SVH
`define ADCRA_DEFS_SVH

// bus and register widths, and the calibration register count
`define ADCRA_DATA_W      16
`define ADCRA_PAYLOAD_W   14
`define ADCRA_RESULT_W    12
`define ADCRA_BYTE_W      8
`define ADCRA_CAL_COUNT   10
`define ADCRA_CAL_IDX_W   4

// word layout: two address bits above a 14-bit payload
`define ADCRA_ADDR_HI     15
`define ADCRA_ADDR_LO     14
`define ADCRA_UPPER_PIN   8

// control register field positions
`define ADCRA_SGL_BIT     13
`define ADCRA_CH_HI       12
`define ADCRA_CH_LO       10
`define ADCRA_PWR_HI      9
`define ADCRA_PWR_LO      8
`define ADCRA_RD_HI       7
`define ADCRA_RD_LO       6
`define ADCRA_ANALOG_RANGE_SELECT_BIT   5
`define ADCRA_CONV_BIT    4
`define ADCRA_CALIBRATION_TYPE_SELECT_BIT   3
`define ADCRA_CALP_HI     2
`define ADCRA_CALP_LO     1
`define ADCRA_CALIBRATION_TRIGGER_BIT   0

// reset values
`define ADCRA_CTRL_RESET  14'h0000
`define ADCRA_TEST_RESET  14'h0000
`define ADCRA_CAL_RESET   14'h0000

// calibration register groups, first and last index for each pick code
`define ADCRA_GRP0_FIRST  4'h0
`define ADCRA_GRP0_LAST   4'h9
`define ADCRA_GRP1_FIRST  4'h0
`define ADCRA_GRP1_LAST   4'h1
`define ADCRA_GRP2_FIRST  4'h2
`define ADCRA_GRP2_LAST   4'h9
`define ADCRA_GRP3_FIRST  4'h0
`define ADCRA_GRP3_LAST   4'h0

`endif

// *** adcra_pkg.sv ***
/*
   types for the converter register access port: write targets, read sources
   and the byte assembly state.
   assumes nothing beyond a SystemVerilog compiler.
*/
package adcra_pkg;

   // write target, in the order of the two address bits
   typedef enum logic [1:0] {
      wt_none,
      wt_test,
      wt_cal,
      wt_ctrl
   } adcra_wr_target_t;

   // read source, in the order of the two read-select bits
   typedef enum logic [1:0] {
      rs_result,
      rs_test,
      rs_cal,
      rs_status
   } adcra_rd_source_t;

   // byte-mode write assembly
   typedef enum logic {
      bs_empty,
      bs_low_held
   } adcra_byte_state_t;

endpackage : adcra_pkg

// *** adcra_word_asm.sv ***
/*
   write capture: samples the parallel data pins during a write strobe and
   delivers one complete 16-bit word, either at once or from two bytes.
   assumes bus pins synchronous to ref_clk and held stable while strobed.
*/
`timescale 1ns/1ps
`include "adcra_defs.svh"

module adcra_word_asm (
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   input  wire logic                      cs_n,
   input  wire logic                      wr_n,
   input  wire logic                      word_mode,
   input  wire logic [`ADCRA_DATA_W-1:0]  data_in,
   output logic      [`ADCRA_DATA_W-1:0]  word_q,
   output logic                           commit_q
);

   logic                          wr_act;
   logic                          wr_act_q;
   logic                          wr_end;
   logic [`ADCRA_DATA_W-1:0]      sample_q;
   logic                          mode_q;
   logic [`ADCRA_BYTE_W-1:0]      low_q;
   adcra_pkg::adcra_byte_state_t  state_q;

   // a write is taken when the strobe is released
   assign wr_act = ~cs_n & ~wr_n;
   assign wr_end = wr_act_q & ~wr_act;

   // follow the strobe and keep the last data seen under it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         wr_act_q <= 1'b0;
         sample_q <= '0;
         mode_q   <= 1'b0;
      end else begin
         wr_act_q <= wr_act;
         if (wr_act) begin
            sample_q <= data_in;
            mode_q   <= word_mode;
         end
      end
   end

   // word mode passes the whole word; byte mode pairs low then high
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_q  <= adcra_pkg::bs_empty;
         low_q    <= '0;
         word_q   <= '0;
         commit_q <= 1'b0;
      end else begin
         commit_q <= 1'b0;
         if (wr_end) begin
            if (mode_q) begin
               word_q   <= sample_q; // R1 R2
               commit_q <= 1'b1;
               state_q  <= adcra_pkg::bs_empty;
            end else begin
               case (state_q)
                  adcra_pkg::bs_empty: begin
                     if (!sample_q[`ADCRA_UPPER_PIN]) begin
                        low_q   <= sample_q[`ADCRA_BYTE_W-1:0]; // R3 R19 R22
                        state_q <= adcra_pkg::bs_low_held;
                     end
                  end
                  adcra_pkg::bs_low_held: begin
                     if (sample_q[`ADCRA_UPPER_PIN]) begin
                        word_q   <= {sample_q[`ADCRA_BYTE_W-1:0], low_q}; // R4 R22
                        commit_q <= 1'b1;
                        state_q  <= adcra_pkg::bs_empty;
                     end else begin
                        low_q <= sample_q[`ADCRA_BYTE_W-1:0]; // newer low byte replaces the held one
                     end
                  end
                  default: begin
                     state_q <= adcra_pkg::bs_empty;
                  end
               endcase
            end
         end
      end
   end

endmodule : adcra_word_asm

// *** adcra_top.sv ***
/*
   register access port of an eight-channel sampling converter: write address
   decode, control, test and calibration registers, read source selection and
   the parallel read path.
   assumes synchronous bus pins, a conversion engine that pulses conv_done and
   supplies the result and status words, and an outside tristate resolver.
*/
`timescale 1ns/1ps
`include "adcra_defs.svh"

// What this block does
// R1 - every write carries one full 16-bit word, as one word or two bytes
// R2 - word mode uses data pins 0 to 15, pin 0 least significant
// R3 - byte mode uses pins 0 to 7; pin 8 becomes the upper byte strobe
// R4 - in byte mode the host writes the low byte before the high byte
// R5 - top two word bits address a register; low 14 bits are stored
// R6 - address 00 none, 01 test, 10 selected calibration, 11 control
// R7 - control bits 7 and 6 choose the read source
// R8 - read source 00 result, 01 test, 10 calibration, 11 status
// R9 - after reset the read source is 00, the conversion result
// R10 - conversion result reads carry four zero bits above the result
// R11 - host reads a calibration register low byte first in byte mode
// R12 - reads keep the selected source until control selects another
// R13 - ten calibration registers; control write-only; result and status read-only
// R14 - host should not write the test register
// R15 - control register is 14 bits, all zero after reset
// R16 - control bit 13: 0 pseudo-differential, 1 single-ended inputs
// R17 - control bits 12 to 10 pick the input; reset picks inputs one and two
// R18 - reset defaults allow full power-down and self-calibration without further writes
// R19 - byte mode: strobe low moves the low byte, high the high byte
// R20 - with calibration trigger 0, calibration pick bits address the calibration register
// R21 - conversion trigger bit starts one conversion and clears when it ends
// R22 - byte mode holds the low byte and commits only after the high byte
// R23 - a write to address 00 changes nothing and has no side effect
module adcra_top (
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   input  wire logic                       cs_n,
   input  wire logic                       rd_n,
   input  wire logic                       wr_n,
   input  wire logic                       word_mode,
   input  wire logic [`ADCRA_DATA_W-1:0]   data_in,
   output logic      [`ADCRA_DATA_W-1:0]   data_out,
   output logic                            data_oe_low,
   output logic                            data_oe_high,
   input  wire logic                       conv_done,
   input  wire logic [`ADCRA_RESULT_W-1:0] conv_result,
   input  wire logic [`ADCRA_DATA_W-1:0]   status_word,
   output logic                            single_ended_select,
   output logic      [2:0]                 channel_pick,
   output logic      [1:0]                 power_option,
   output logic                            analog_range_select,
   output logic                            software_conversion_trigger,
   output logic                            calibration_type_select,
   output logic      [1:0]                 calibration_pick,
   output logic                            calibration_trigger,
   output logic                            calibration_start,
   output logic      [`ADCRA_CAL_IDX_W-1:0] calibration_index,
   output logic      [`ADCRA_PAYLOAD_W-1:0] test_word
);

   localparam int CAL_COUNT = `ADCRA_CAL_COUNT;

   logic [`ADCRA_DATA_W-1:0]      asm_word;
   logic                          asm_commit;
   adcra_pkg::adcra_wr_target_t   wr_target;
   logic [`ADCRA_PAYLOAD_W-1:0]   wr_payload;
   logic                          ctrl_wr;
   logic                          test_wr;
   logic                          cal_wr;
   logic [`ADCRA_PAYLOAD_W-1:0]   ctrl_q;
   logic [`ADCRA_PAYLOAD_W-1:0]   test_q;
   logic [`ADCRA_PAYLOAD_W-1:0]   cal_mem [CAL_COUNT];
   logic [`ADCRA_CAL_IDX_W-1:0]   cal_ptr_q;
   logic                          cal_start_q;
   adcra_pkg::adcra_rd_source_t   rd_source;
   logic                          rd_act;
   logic                          rd_act_q;
   logic                          rd_end;
   logic                          rd_upper_q;
   logic                          rd_mode_q;
   logic                          cal_rd_done;
   logic [`ADCRA_DATA_W-1:0]      rd_word;
   logic [`ADCRA_DATA_W-1:0]      data_out_q;
   logic                          oe_low_q;
   logic                          oe_high_q;

   // first calibration index of the group that a pick code addresses
   function automatic logic [`ADCRA_CAL_IDX_W-1:0] group_first(input logic [1:0] pick);
      case (pick)
         2'h0:    group_first = `ADCRA_GRP0_FIRST;
         2'h1:    group_first = `ADCRA_GRP1_FIRST;
         2'h2:    group_first = `ADCRA_GRP2_FIRST;
         default: group_first = `ADCRA_GRP3_FIRST;
      endcase
   endfunction : group_first

   // index after ptr inside the group, wrapping to its first entry
   function automatic logic [`ADCRA_CAL_IDX_W-1:0] group_next(input logic [`ADCRA_CAL_IDX_W-1:0] ptr,
                                                             input logic [1:0]                  pick);
      logic [`ADCRA_CAL_IDX_W-1:0] last;
      case (pick)
         2'h0:    last = `ADCRA_GRP0_LAST;
         2'h1:    last = `ADCRA_GRP1_LAST;
         2'h2:    last = `ADCRA_GRP2_LAST;
         default: last = `ADCRA_GRP3_LAST;
      endcase
      if (ptr >= last) begin
         group_next = group_first(pick);
      end else begin
         group_next = ptr + 4'h1;
      end
   endfunction : group_next

   // write capture and byte pairing
   adcra_word_asm u_word_asm (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .cs_n      (cs_n),
      .wr_n      (wr_n),
      .word_mode (word_mode),
      .data_in   (data_in),
      .word_q    (asm_word),
      .commit_q  (asm_commit)
   );

   // address decode of a committed word
   assign wr_target  = adcra_pkg::adcra_wr_target_t'(asm_word[`ADCRA_ADDR_HI:`ADCRA_ADDR_LO]); // R5
   assign wr_payload = asm_word[`ADCRA_PAYLOAD_W-1:0]; // R5
   assign ctrl_wr    = asm_commit & (wr_target == adcra_pkg::wt_ctrl); // R6
   assign test_wr    = asm_commit & (wr_target == adcra_pkg::wt_test); // R6 R14
   assign cal_wr     = asm_commit & (wr_target == adcra_pkg::wt_cal)
                       & ~ctrl_q[`ADCRA_CALIBRATION_TRIGGER_BIT]; // R6 R20
   // address 00 raises none of the strobes above, so nothing moves  R23

   // control register; conversion trigger clears at conversion end
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl_q <= `ADCRA_CTRL_RESET; // R9 R15 R17 R18
      end else if (ctrl_wr) begin
         ctrl_q <= wr_payload; // R15 R12
      end else if (conv_done) begin
         ctrl_q[`ADCRA_CONV_BIT] <= 1'b0; // R21
      end
   end

   // one-cycle start of a calibration when the trigger bit is written as 1
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cal_start_q <= 1'b0;
      end else begin
         cal_start_q <= ctrl_wr & wr_payload[`ADCRA_CALIBRATION_TRIGGER_BIT];
      end
   end

   // test register, readable and writable
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         test_q <= `ADCRA_TEST_RESET;
      end else if (test_wr) begin
         test_q <= wr_payload; // R13
      end
   end

   // calibration bank
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < CAL_COUNT; i++) begin
            cal_mem[i] <= `ADCRA_CAL_RESET;
         end
      end else if (cal_wr && (cal_ptr_q < 4'(CAL_COUNT))) begin
         cal_mem[cal_ptr_q] <= wr_payload; // R13 R20
      end
   end

   // calibration pointer: restarts on each control write, steps per word
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cal_ptr_q <= `ADCRA_GRP0_FIRST;
      end else if (ctrl_wr) begin
         cal_ptr_q <= group_first(wr_payload[`ADCRA_CALP_HI:`ADCRA_CALP_LO]); // R20
      end else if (cal_wr || cal_rd_done) begin
         cal_ptr_q <= group_next(cal_ptr_q, ctrl_q[`ADCRA_CALP_HI:`ADCRA_CALP_LO]); // R20
      end
   end

   // read source and the word it presents
   assign rd_source = adcra_pkg::adcra_rd_source_t'(ctrl_q[`ADCRA_RD_HI:`ADCRA_RD_LO]); // R7

   always_comb begin
      case (rd_source) // R8 R12
         adcra_pkg::rs_result: rd_word = {4'h0, conv_result}; // R10
         adcra_pkg::rs_test:   rd_word = {2'h0, test_q};
         adcra_pkg::rs_cal:    rd_word = (cal_ptr_q < 4'(CAL_COUNT)) ? {2'h0, cal_mem[cal_ptr_q]} : 16'h0000;
         adcra_pkg::rs_status: rd_word = status_word;
         default:              rd_word = 16'h0000;
      endcase
   end

   // read strobe tracking; calibration word counts as read after its high byte
   assign rd_act      = ~cs_n & ~rd_n;
   assign rd_end      = rd_act_q & ~rd_act;
   assign cal_rd_done = rd_end & (rd_source == adcra_pkg::rs_cal)
                        & ~ctrl_q[`ADCRA_CALIBRATION_TRIGGER_BIT]
                        & (rd_mode_q | rd_upper_q); // R11 R20

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_act_q   <= 1'b0;
         rd_upper_q <= 1'b0;
         rd_mode_q  <= 1'b0;
      end else begin
         rd_act_q <= rd_act;
         if (rd_act) begin
            rd_upper_q <= data_in[`ADCRA_UPPER_PIN];
            rd_mode_q  <= word_mode;
         end
      end
   end

   // drive the data pins while a read is strobed
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         data_out_q <= '0;
         oe_low_q   <= 1'b0;
         oe_high_q  <= 1'b0;
      end else begin
         oe_low_q  <= rd_act;
         oe_high_q <= rd_act & word_mode; // R3
         if (!rd_act) begin
            data_out_q <= '0;
         end else if (word_mode) begin
            data_out_q <= rd_word; // R2
         end else if (data_in[`ADCRA_UPPER_PIN]) begin
            data_out_q <= {8'h00, rd_word[`ADCRA_DATA_W-1:`ADCRA_BYTE_W]}; // R19
         end else begin
            data_out_q <= {8'h00, rd_word[`ADCRA_BYTE_W-1:0]}; // R19
         end
      end
   end

   // outputs straight from flip-flops
   assign data_out                    = data_out_q;
   assign data_oe_low                 = oe_low_q;
   assign data_oe_high                = oe_high_q;
   assign single_ended_select         = ctrl_q[`ADCRA_SGL_BIT]; // R16
   assign channel_pick                = ctrl_q[`ADCRA_CH_HI:`ADCRA_CH_LO]; // R17
   assign power_option                = ctrl_q[`ADCRA_PWR_HI:`ADCRA_PWR_LO];
   assign analog_range_select         = ctrl_q[`ADCRA_ANALOG_RANGE_SELECT_BIT];
   assign software_conversion_trigger = ctrl_q[`ADCRA_CONV_BIT]; // R21
   assign calibration_type_select     = ctrl_q[`ADCRA_CALIBRATION_TYPE_SELECT_BIT];
   assign calibration_pick            = ctrl_q[`ADCRA_CALP_HI:`ADCRA_CALP_LO];
   assign calibration_trigger         = ctrl_q[`ADCRA_CALIBRATION_TRIGGER_BIT];
   assign calibration_start           = cal_start_q;
   assign calibration_index           = cal_ptr_q;
   assign test_word                   = test_q;

endmodule : adcra_top

// *** adcra_top_sva.sv ***
/*
   checker for the converter register access port: read strobe answers, reset
   values and write-free stability of the control outputs.
   assumes it is bound to adcra_top and sees only its ports.
*/
`timescale 1ns/1ps
`include "adcra_defs.svh"

module adcra_top_chk (
   input wire logic                         ref_clk,
   input wire logic                         rst_n,
   input wire logic                         cs_n,
   input wire logic                         rd_n,
   input wire logic                         wr_n,
   input wire logic                         word_mode,
   input wire logic [`ADCRA_DATA_W-1:0]     data_out,
   input wire logic                         data_oe_low,
   input wire logic                         data_oe_high,
   input wire logic                         conv_done,
   input wire logic                         single_ended_select,
   input wire logic [2:0]                   channel_pick,
   input wire logic [1:0]                   power_option,
   input wire logic                         software_conversion_trigger,
   input wire logic                         calibration_trigger,
   input wire logic                         calibration_start,
   input wire logic [1:0]                   calibration_pick,
   input wire logic [`ADCRA_PAYLOAD_W-1:0]  test_word
);
   default clocking chk_cb @(posedge ref_clk);
   endclocking

   // four sampled edges with no write strobe under way
   sequence bus_idle4;
      (cs_n || wr_n) [*4];
   endsequence

   // an edge that samples an active read strobe
   sequence read_seen;
      !cs_n && !rd_n;
   endsequence

   a_reset_quiet: assert property (!rst_n |=> (data_out == 16'h0000 && !data_oe_low && !data_oe_high
      && channel_pick == 3'h0 && !single_ended_select && !calibration_start && test_word == 14'h0000))
      else $error("outputs not cleared by reset");
   a_read_answer: assert property (disable iff (!rst_n) read_seen |=> data_oe_low)
      else $error("read strobe not answered on the low byte lane");
   a_upper_drive: assert property (disable iff (!rst_n) read_seen |=> data_oe_high == $past(word_mode))
      else $error("upper lane drive does not follow word mode");
   a_read_drop: assert property (disable iff (!rst_n) (cs_n || rd_n) |=>
      (!data_oe_low && !data_oe_high && data_out == 16'h0000))
      else $error("data pins still driven after read release");
   a_byte_upper: assert property (disable iff (!rst_n) (data_oe_low && !data_oe_high) |->
      data_out[15:8] == 8'h00)
      else $error("byte read shows bits above the low byte");
   a_ctrl_hold: assert property (disable iff (!rst_n) bus_idle4 |=> ($stable(channel_pick)
      && $stable(single_ended_select) && $stable(power_option) && $stable(test_word)
      && $stable(calibration_pick)))
      else $error("register outputs changed with no write");
   a_trig_clear: assert property (disable iff (!rst_n) bus_idle4 ##0 software_conversion_trigger |=>
      software_conversion_trigger != $past(conv_done))
      else $error("conversion trigger did not follow conversion end");
   a_cal_start: assert property (disable iff (!rst_n) calibration_start |->
      calibration_trigger ##1 !calibration_start)
      else $error("calibration start pulse wrong");
   a_cal_rise: assert property (disable iff (!rst_n) $rose(calibration_trigger) |-> calibration_start)
      else $error("calibration start missing");
endmodule : adcra_top_chk

bind adcra_top adcra_top_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
   .word_mode(word_mode), .data_out(data_out), .data_oe_low(data_oe_low), .data_oe_high(data_oe_high),
   .conv_done(conv_done), .single_ended_select(single_ended_select), .channel_pick(channel_pick),
   .power_option(power_option), .software_conversion_trigger(software_conversion_trigger),
   .calibration_trigger(calibration_trigger), .calibration_start(calibration_start),
   .calibration_pick(calibration_pick), .test_word(test_word));

// *** adcra_host.sv ***
/*
   host model: drives the parallel bus strobes and data pins of the register port.
   assumes the device samples its pins on the rising edge of ref_clk.
*/
`timescale 1ns/1ps
`include "adcra_defs.svh"

module adcra_host (
   input  wire logic                     ref_clk,
   output logic                          cs_n,
   output logic                          rd_n,
   output logic                          wr_n,
   output logic                          word_mode,
   output logic     [`ADCRA_DATA_W-1:0]  data_in,
   input  wire logic [`ADCRA_DATA_W-1:0] data_out,
   input  wire logic                     data_oe_low,
   input  wire logic                     data_oe_high
);
   // bus idle at time zero
   initial begin
      cs_n      = 1'h1;
      rd_n      = 1'h1;
      wr_n      = 1'h1;
      word_mode = 1'h1;
      data_in   = 16'h0000;
   end

   // one strobed write, then released pins show inverted data
   task automatic wr_cycle(input logic wm, input logic [15:0] pins);
      @(posedge ref_clk);
      cs_n      <= 1'h0;
      wr_n      <= 1'h0;
      word_mode <= wm;
      data_in   <= pins;
      @(posedge ref_clk);
      cs_n    <= 1'h1;
      wr_n    <= 1'h1;
      data_in <= ~pins;
      repeat (4) @(posedge ref_clk);
   endtask : wr_cycle

   // whole word on pins 0 to 15
   task automatic wr_word(input logic [15:0] w);
      wr_cycle(1'h1, w);
   endtask : wr_word

   // low byte first, then the high byte with the upper byte strobe set
   task automatic wr_bytes(input logic [15:0] w);
      wr_cycle(1'h0, {7'h00, 1'h0, w[7:0]});
      wr_cycle(1'h0, {7'h00, 1'h1, w[15:8]});
   endtask : wr_bytes

   // read strobe held two edges; data pins released apart from the strobe pin
   task automatic rd_cycle(input logic wm, input logic hi, output logic [15:0] val, output logic [1:0] oe);
      @(posedge ref_clk);
      cs_n      <= 1'h0;
      rd_n      <= 1'h0;
      word_mode <= wm;
      data_in   <= {~data_in[15:9], hi, ~data_in[7:0]};
      repeat (2) @(posedge ref_clk);
      val = data_out;
      oe  = {data_oe_high, data_oe_low};
      cs_n <= 1'h1;
      rd_n <= 1'h1;
      @(posedge ref_clk);
   endtask : rd_cycle
endmodule : adcra_host

// *** test_adc_register_access_port.sv ***
/*
   self-checking testbench for the converter register access port.
   assumes adcra_top, adcra_host and the bound checker are compiled beside it.
*/
`timescale 1ns/1ps
`include "adcra_defs.svh"

module test_adc_register_access_port;
   logic        ref_clk, rst_n, cs_n, rd_n, wr_n, word_mode, data_oe_low, data_oe_high, conv_done;
   logic [15:0] data_in, data_out, status_word, rv;
   logic [11:0] conv_result;
   logic        single_ended_select, analog_range_select, software_conversion_trigger;
   logic        calibration_type_select, calibration_trigger, calibration_start;
   logic [2:0]  channel_pick;
   logic [1:0]  power_option, calibration_pick, oe;
   logic [3:0]  calibration_index;
   logic [13:0] test_word;
   int          fail_count, checks_done;
   wire logic [15:0] ctl_seen = {2'h0, single_ended_select, channel_pick, power_option, 2'h0,
      analog_range_select, software_conversion_trigger, calibration_type_select, calibration_pick,
      calibration_trigger};

   adcra_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .word_mode(word_mode), .data_in(data_in), .data_out(data_out), .data_oe_low(data_oe_low),
      .data_oe_high(data_oe_high), .conv_done(conv_done), .conv_result(conv_result),
      .status_word(status_word), .single_ended_select(single_ended_select), .channel_pick(channel_pick),
      .power_option(power_option), .analog_range_select(analog_range_select),
      .software_conversion_trigger(software_conversion_trigger),
      .calibration_type_select(calibration_type_select), .calibration_pick(calibration_pick),
      .calibration_trigger(calibration_trigger), .calibration_start(calibration_start),
      .calibration_index(calibration_index), .test_word(test_word));
   adcra_host host_u (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .word_mode(word_mode),
      .data_in(data_in), .data_out(data_out), .data_oe_low(data_oe_low), .data_oe_high(data_oe_high));

   // 200 MHz clock
   initial ref_clk = 1'h0;
   always #2.5 ref_clk = ~ref_clk;

   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // verdict and end of run
   task automatic results();
      if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results

   // reset values and the default read source in both bus widths
   task automatic t_reset();
      check(ctl_seen, 16'h0000);
      host_u.rd_cycle(1'h1, 1'h0, rv, oe);
      check(rv, 16'h09c3);
      check({14'h0, oe}, 16'h0003);
      host_u.rd_cycle(1'h0, 1'h1, rv, oe);
      check(rv, 16'h0009);
      check({14'h0, oe}, 16'h0001);
   endtask : t_reset

   // control fields, then a write to the empty address
   task automatic t_fields();
      host_u.wr_word(16'hf62c);
      check(ctl_seen, 16'h362c);
      host_u.wr_word(16'h3fff);
      check(ctl_seen, 16'h362c);
      check({2'h0, test_word}, 16'h0000);
   endtask : t_fields

   // test register written as a word and read back as word and bytes
   task automatic t_test();
      host_u.wr_word(16'h6a5c);
      check({2'h0, test_word}, 16'h2a5c);
      host_u.wr_word(16'hc040);
      repeat (2) begin
         host_u.rd_cycle(1'h1, 1'h0, rv, oe);
         check(rv, 16'h2a5c);
      end
      host_u.rd_cycle(1'h0, 1'h0, rv, oe);
      check(rv, 16'h005c);
      host_u.rd_cycle(1'h0, 1'h1, rv, oe);
      check(rv, 16'h002a);
   endtask : t_test

   // byte writes: lone high byte dropped, low byte held until the high byte
   task automatic t_bytes();
      host_u.wr_cycle(1'h0, 16'h0141);
      check({2'h0, test_word}, 16'h2a5c);
      host_u.wr_cycle(1'h0, 16'h0023);
      check({2'h0, test_word}, 16'h2a5c);
      host_u.wr_cycle(1'h0, 16'h0141);
      check({2'h0, test_word}, 16'h0123);
   endtask : t_bytes

   // all ten calibration registers written then read back in order
   task automatic t_cal();
      host_u.wr_word(16'hc000);
      for (int i = 0; i < 10; i++) host_u.wr_word(16'h8000 | (16'(i) * 16'h0123));
      host_u.wr_word(16'hc080);
      for (int i = 0; i < 10; i++) begin
         host_u.rd_cycle(1'h1, 1'h0, rv, oe);
         check(rv, 16'(i) * 16'h0123);
      end
      host_u.wr_word(16'hc084);
      check({12'h0, calibration_index}, 16'h0002);
      host_u.rd_cycle(1'h1, 1'h0, rv, oe);
      check(rv, 16'h0246);
   endtask : t_cal

   // status source, conversion and calibration triggers, then a reset in mid-run
   task automatic t_status_conv();
      status_word <= 16'hbeef;
      host_u.wr_bytes(16'hc0c0);
      host_u.rd_cycle(1'h1, 1'h0, rv, oe);
      check(rv, 16'hbeef);
      host_u.wr_word(16'hc010);
      check({15'h0, software_conversion_trigger}, 16'h0001);
      conv_done <= 1'h1;
      @(posedge ref_clk);
      conv_done <= 1'h0;
      repeat (2) @(posedge ref_clk);
      check({15'h0, software_conversion_trigger}, 16'h0000);
      host_u.wr_word(16'hc001);
      check({15'h0, calibration_trigger}, 16'h0001);
      conv_result <= ~conv_result;
      rst_n       <= 1'h0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      check(ctl_seen, 16'h0000);
      host_u.rd_cycle(1'h1, 1'h0, rv, oe);
      check(rv, 16'h063c);
   endtask : t_status_conv

   // main sequence
   initial begin
      rst_n       = 1'h0;
      conv_done   = 1'h0;
      conv_result = 12'h9c3;
      status_word = 16'h0000;
      fail_count  = 0;
      checks_done = 0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
      t_reset();
      t_fields();
      t_test();
      t_bytes();
      t_cal();
      t_status_conv();
      results();
   end

   // watchdog
   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      results();
   end
endmodule : test_adc_register_access_port
